// ### ssp_top.sv
// serial peripheral port, master or slave, with AXI4-Lite registers
// ----------------------------------------------------------------
// Summary of operation
// - master_select high makes the port bus master, low makes it slave.
// - only the master starts a transfer, always by a data register write.
// - in master mode a data write starts sending and receiving one byte.
// - data writes load the shift register when idle or unselected; reads return the rx buffer.
// - as master the byte shifts out on mosi while miso shifts in.
// - after eight bits hardware sets the transfer complete flag.
// - when the flag sets, the received byte goes to the rx buffer.
// - in slave mode the clock pin is an input driving the shifter.
// - in slave mode the select pin is an input.
// - a slave exchanges no data until select is driven low.
// - mode_fault_disable at bit 3 acts only in master mode.
// - fault detection enabled makes select a fault input as master.
// - fault detection disabled lets select_output_enable set the pin.
// ----------------------------------------------------------------
`timescale 1ns/1ns
module ssp_top
    import ssp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ssp_pins_in_t pins_in,
    output ssp_pins_out_t pins_out,
    output logic irq
);
    // ----------------------------------------------------------------
    // state and registers
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SSP_IDLE = 3'b001,
        SSP_LEAD = 3'b010,
        SSP_TRAIL = 3'b100
    } ssp_state_t;

    ssp_state_t state;
    logic [7:0] serial_control_reg;
    logic [7:0] shift;
    logic [7:0] serial_shift_data;
    logic [7:0] irq_mask;
    logic [7:0] half_div;
    logic [3:0] bit_count;
    logic done_flag;
    logic modf_flag;
    logic sck_out;
    logic [2:0] pin_sync;
    logic miso_s;
    logic sck_s;
    logic ss_s;
    logic sck_prev;
    logic tick;
    logic master_select;
    logic modf_on;
    logic ss_is_out;
    logic xfer_end;
    logic modf_event;
    logic slave_sel;
    logic sck_rise;
    logic rx_bit;

    assign master_select = serial_control_reg[SSP_CTRL_MASTER];
    // fault input whenever master with detection enabled
    assign modf_on = master_select
        && !serial_control_reg[SSP_CTRL_MODF_DIS];
    assign ss_is_out = master_select && !modf_on
        && serial_control_reg[SSP_CTRL_SS_OE];

    // ----------------------------------------------------------------
    // pin synchronisers and divider
    // ----------------------------------------------------------------
    ssp_sync #(.WIDTH(3)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({pins_in.miso, pins_in.sck, pins_in.ss_n}),
        .dout(pin_sync)
    );
    assign miso_s = pin_sync[2];
    assign sck_s = pin_sync[1];
    assign ss_s = pin_sync[0];

    ssp_divider u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(state != SSP_IDLE),
        .half_div(half_div),
        .tick(tick)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // same level as the synchroniser reset, no false edge
            sck_prev <= 1'b1;
        end else begin
            sck_prev <= sck_s;
        end
    end
    assign sck_rise = sck_s && !sck_prev;
    assign slave_sel = !master_select && !ss_s;
    assign modf_event = modf_on && !ss_s;

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic wr_data;
    logic wr_ctrl;
    logic wr_stat;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_data = wr_fire && aw_addr == SSP_ADDR_DATA && w_strb[0];
    assign wr_ctrl = wr_fire && aw_addr == SSP_ADDR_CTRL && w_strb[0];
    assign wr_stat = wr_fire && aw_addr == SSP_ADDR_STAT && w_strb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SSP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (aw_addr)
                    SSP_ADDR_DATA, SSP_ADDR_CTRL, SSP_ADDR_STAT,
                    SSP_ADDR_MASK, SSP_ADDR_DIV: begin
                        s_axi_bresp <= SSP_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= SSP_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_control_reg <= SSP_CTRL_RST;
            irq_mask <= SSP_MASK_RST;
            half_div <= SSP_DIV_RST;
        end else if (wr_fire && w_strb[0]) begin
            if (aw_addr == SSP_ADDR_CTRL) begin
                serial_control_reg <= w_data[7:0];
            end
            if (aw_addr == SSP_ADDR_MASK) begin
                irq_mask <= w_data[7:0];
            end
            if (aw_addr == SSP_ADDR_DIV) begin
                half_div <= w_data[7:0];
            end
        end else if (modf_event) begin
            // mode fault drops the port back to slave
            serial_control_reg[SSP_CTRL_MASTER] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;
    logic [1:0] rd_resp;

    always_comb begin
        rd_mux = 8'h00;
        rd_resp = SSP_RESP_OKAY;
        unique case (s_axi_araddr)
            SSP_ADDR_DATA: rd_mux = serial_shift_data;
            SSP_ADDR_CTRL: rd_mux = serial_control_reg;
            SSP_ADDR_STAT: begin
                rd_mux[SSP_STAT_DONE] = done_flag;
                rd_mux[SSP_STAT_MODF] = modf_flag;
            end
            SSP_ADDR_MASK: rd_mux = irq_mask;
            SSP_ADDR_DIV: rd_mux = half_div;
            default: rd_resp = SSP_RESP_SLVERR;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= SSP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_mux};
            s_axi_rresp <= rd_resp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // shift engine
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= SSP_IDLE;
            shift <= SSP_DATA_RST;
            bit_count <= 4'h0;
            sck_out <= 1'b0;
            rx_bit <= 1'b0;
            xfer_end <= 1'b0;
        end else begin
            xfer_end <= 1'b0;
            if (master_select) begin
                unique case (state)
                    SSP_IDLE: begin
                        sck_out <= 1'b0;
                        bit_count <= 4'h0;
                        if (wr_data) begin
                            shift <= w_data[7:0];
                            state <= SSP_LEAD;
                        end
                    end
                    SSP_LEAD: begin
                        if (modf_event) begin
                            state <= SSP_IDLE;
                        end else if (tick) begin
                            sck_out <= 1'b1;
                            rx_bit <= miso_s;
                            bit_count <= bit_count + 4'h1;
                            state <= SSP_TRAIL;
                        end
                    end
                    SSP_TRAIL: begin
                        if (modf_event) begin
                            state <= SSP_IDLE;
                        end else if (tick) begin
                            sck_out <= 1'b0;
                            shift <= {shift[6:0], rx_bit};
                            if (bit_count == SSP_BITS) begin
                                xfer_end <= 1'b1;
                                state <= SSP_IDLE;
                            end else begin
                                state <= SSP_LEAD;
                            end
                        end
                    end
                    default: state <= SSP_IDLE;
                endcase
            end else begin
                state <= SSP_IDLE;
                sck_out <= 1'b0;
                if (wr_data && ss_s) begin
                    shift <= w_data[7:0];
                end
                if (!slave_sel) begin
                    bit_count <= 4'h0;
                end else if (sck_rise) begin
                    shift <= {shift[6:0], miso_s};
                    if (bit_count == SSP_BITS - 4'h1) begin
                        bit_count <= 4'h0;
                        xfer_end <= 1'b1;
                    end else begin
                        bit_count <= bit_count + 4'h1;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // receive buffer, flags and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_shift_data <= SSP_DATA_RST;
        end else if (xfer_end) begin
            serial_shift_data <= shift;
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_flag <= 1'b0;
            modf_flag <= 1'b0;
        end else begin
            if (xfer_end) begin
                done_flag <= 1'b1;
            end else if (wr_stat && w_data[SSP_STAT_DONE]) begin
                done_flag <= 1'b0;
            end
            if (modf_event) begin
                modf_flag <= 1'b1;
            end else if (wr_stat && w_data[SSP_STAT_MODF]) begin
                modf_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (done_flag && irq_mask[SSP_STAT_DONE])
                || (modf_flag && irq_mask[SSP_STAT_MODF]);
        end
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_out <= '0;
        end else begin
            pins_out.mosi <= shift[7];
            pins_out.mosi_oe <= master_select;
            pins_out.sck <= sck_out;
            pins_out.sck_oe <= master_select;
            pins_out.ss_n <= state == SSP_IDLE;
            pins_out.ss_n_oe <= ss_is_out;
        end
    end
    // slave out bit shares the mosi field while mosi_oe is low
endmodule

// ### ssp_pkg.sv
// shared constants and types for the serial port
package ssp_pkg;
    // register byte addresses (data word index F5 times four gives 3D4)
    localparam logic [7:0] SSP_IDX_DATA = 8'hF5;
    localparam logic [11:0] SSP_ADDR_DATA = 12'h3D4;
    localparam logic [11:0] SSP_ADDR_CTRL = 12'h400;
    localparam logic [11:0] SSP_ADDR_STAT = 12'h404;
    localparam logic [11:0] SSP_ADDR_MASK = 12'h408;
    localparam logic [11:0] SSP_ADDR_DIV = 12'h40C;
    // control field positions
    localparam int SSP_CTRL_MODF_DIS = 3;
    localparam int SSP_CTRL_MASTER = 4;
    localparam int SSP_CTRL_SS_OE = 7;
    // status field positions
    localparam int SSP_STAT_DONE = 7;
    localparam int SSP_STAT_MODF = 4;
    // reset values, bit count and response codes
    localparam logic [7:0] SSP_DATA_RST = 8'h00;
    localparam logic [7:0] SSP_CTRL_RST = 8'h00;
    localparam logic [7:0] SSP_MASK_RST = 8'h00;
    localparam logic [7:0] SSP_DIV_RST = 8'h03;
    localparam logic [3:0] SSP_BITS = 4'h8;
    localparam logic [1:0] SSP_RESP_OKAY = 2'h0;
    localparam logic [1:0] SSP_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic mosi;
        logic mosi_oe;
        logic sck;
        logic sck_oe;
        logic ss_n;
        logic ss_n_oe;
    } ssp_pins_out_t;

    typedef struct packed {
        logic miso;
        logic sck;
        logic ss_n;
    } ssp_pins_in_t;
endpackage

// ### ssp_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module ssp_sync
    import ssp_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '1;
            dout <= '1;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// ### ssp_divider.sv
// serial clock divider: one-cycle enable per half period
`timescale 1ns/1ns
module ssp_divider
    import ssp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic [7:0] half_div,
    output logic tick
);
    logic [7:0] count;

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            count <= 8'h00;
            tick <= 1'b0;
        end else if (count >= half_div) begin
            count <= 8'h00;
            tick <= 1'b1;
        end else begin
            count <= count + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule

// ### ssp_assertions.sv
// concurrent checks on the serial port top ports
`timescale 1ns/1ns
module ssp_chk
    import ssp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire ssp_pins_in_t pins_in,
    input wire ssp_pins_out_t pins_out,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    upper_zero_a: assert property (
        s_axi_rvalid && s_axi_rresp == SSP_RESP_OKAY |-> s_axi_rdata[31:8] == '0)
        else $error("upper read bits set");
    oe_pair_a: assert property (
        pins_out.sck_oe == pins_out.mosi_oe)
        else $error("clock and data enables differ");
    slave_pins_a: assert property (
        !pins_out.sck_oe |-> !pins_out.ss_n_oe)
        else $error("slave drives select");
    sck_half_a: assert property (
        pins_out.sck_oe && $rose(pins_out.sck) |-> pins_out.sck[*4] ##1 !pins_out.sck)
        else $error("clock high phase wrong");
    fault_abort_a: assert property (
        pins_out.sck_oe && !pins_out.ss_n_oe && $fell(pins_in.ss_n)
        |-> ##[1:8] !pins_out.sck_oe)
        else $error("mode fault missed");
    cover property ($rose(pins_out.sck));
    cover property ($fell(pins_out.sck_oe));
    cover property ($rose(irq));
endmodule
bind ssp_top ssp_chk u_chk (.*);

// ### ssp_far.sv
// far side model: slave for master mode, master for slave mode
`timescale 1ns/1ns
module ssp_far
    import ssp_pkg::*;
(
    input wire logic far_mst,
    input wire logic ss_pull,
    input wire ssp_pins_out_t pins_out,
    output ssp_pins_in_t pins_in
);
    logic [7:0] sl_tx = 8'h00;
    logic [7:0] sl_sh = 8'h00;
    logic [7:0] sl_rx = 8'h00;
    logic [7:0] m_rx = 8'h00;
    logic m_sck = 1'b0;
    logic m_ss = 1'b1;
    logic m_d = 1'b0;
    logic last = 1'b0;
    wire sel = pins_out.ss_n_oe && !pins_out.ss_n;
    // slave: first bit out before first rise, shift on fall
    always @(posedge sel) sl_sh = sl_tx;
    always @(posedge pins_out.sck)
        if (sel) sl_rx = {sl_rx[6:0], pins_out.mosi};
    always @(negedge pins_out.sck) begin
        if (sel) begin
            last = sl_sh[7];
            sl_sh = sl_sh << 1;
        end
    end
    // released data line shows the inverse of its last bit
    always_comb begin
        pins_in.sck = pins_out.sck_oe ? pins_out.sck : m_sck;
        pins_in.ss_n = far_mst ? m_ss
            : (pins_out.ss_n_oe ? pins_out.ss_n : ss_pull);
        pins_in.miso = far_mst ? m_d : (sel ? sl_sh[7] : !last);
    end
    // master: n bits, select level s, clock still outside frames
    task automatic xfer(input logic [7:0] tx, input int n, input logic s);
        m_ss = s;
        #43;
        for (int i = 7; i > 7 - n; i--) begin
            m_d = tx[i];
            #40 m_sck = 1'b1;
            m_rx = {m_rx[6:0], pins_out.mosi};
            #40 m_sck = 1'b0;
        end
        m_d = !m_d;
        #40 m_ss = 1'b1;
    endtask
endmodule

// ### tb_spi_master_slave_port.sv
// self-checking bench for the serial port top
`timescale 1ns/1ns
module tb_spi_master_slave_port
    import ssp_pkg::*;
;
    localparam logic [1:0] ok = SSP_RESP_OKAY;
    logic aclk;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = '0;
    logic [11:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [31:0] s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, irq;
    logic far_mst = 1'b0, ss_pull = 1'b1;
    ssp_pins_in_t pins_in;
    ssp_pins_out_t pins_out;
    logic [7:0] txv [2] = '{8'hA5, 8'h01};
    logic [7:0] rxv [2] = '{8'h3C, 8'hFE};
    int error_cnt = 0;
    int comparisons = 0;
    ssp_top uut (.*);
    ssp_far far (.*);
    initial begin
        aclk = 1'b0;
        forever #2 aclk = !aclk;
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic results;
        if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
            input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!s_axi_bvalid);
                chk("bresp", s_axi_bresp, er);
                s_axi_bready <= 1'b0;
            end
        join
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] ex,
            input logic [1:0] er);
        logic [31:0] v;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!s_axi_arready);
                s_axi_arvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!s_axi_rvalid);
                v = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        join
        chk("rresp", r, er);
        if (er === ok) chk("rdata", v, {24'h000000, ex});
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        results;
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(SSP_ADDR_DATA, 8'h00, ok);
        rd(SSP_ADDR_CTRL, SSP_CTRL_RST, ok);
        rd(SSP_ADDR_STAT, 8'h00, ok);
        rd(SSP_ADDR_MASK, SSP_MASK_RST, ok);
        rd(SSP_ADDR_DIV, SSP_DIV_RST, ok);
        rd(12'h010, 8'h00, SSP_RESP_SLVERR);
        wr(12'h010, 8'h00, SSP_RESP_SLVERR);
        far.sl_tx = rxv[0];
        wr(SSP_ADDR_CTRL, 8'h98, ok);
        @(negedge aclk);
        chk("ss_oe", pins_out.ss_n_oe, 1'b1);
        chk("sck_oe", pins_out.sck_oe, 1'b1);
        // master: mask set then cleared, buffer read mid transfer
        for (int i = 0; i < 2; i++) begin
            far.sl_tx = rxv[i];
            wr(SSP_ADDR_MASK, (i == 0) ? 8'h80 : 8'h00, ok);
            wr(SSP_ADDR_DATA, txv[i], ok);
            rd(SSP_ADDR_DATA, (i == 0) ? 8'h00 : rxv[0], ok);
            wait (pins_out.ss_n);
            repeat (4) @(posedge aclk);
            chk("far_rx", far.sl_rx, txv[i]);
            chk("irq", irq, i == 0);
            rd(SSP_ADDR_STAT, 8'h80, ok);
            rd(SSP_ADDR_DATA, rxv[i], ok);
            wr(SSP_ADDR_STAT, 8'h80, ok);
            rd(SSP_ADDR_STAT, 8'h00, ok);
            chk("irq", irq, 1'b0);
        end
        wr(SSP_ADDR_CTRL, 8'h10, ok);
        ss_pull <= 1'b0;
        wait (!pins_out.sck_oe);
        rd(SSP_ADDR_STAT, 8'h10, ok);
        rd(SSP_ADDR_CTRL, 8'h00, ok);
        ss_pull <= 1'b1;
        wr(SSP_ADDR_STAT, 8'h10, ok);
        // slave: unselected and partial frames set no done flag
        wr(SSP_ADDR_CTRL, 8'h08, ok);
        @(negedge aclk);
        chk("slv_oe", {pins_out.sck_oe, pins_out.ss_n_oe}, 2'b00);
        wr(SSP_ADDR_DATA, 8'h5A, ok);
        far_mst <= 1'b1;
        @(posedge aclk);
        far.xfer(8'hFF, 8, 1'b1);
        far.xfer(8'hC3, 4, 1'b0);
        rd(SSP_ADDR_STAT, 8'h00, ok);
        wr(SSP_ADDR_DATA, 8'h5A, ok);
        far.xfer(8'h96, 8, 1'b0);
        chk("far_rx", far.m_rx, 8'h5A);
        rd(SSP_ADDR_STAT, 8'h80, ok);
        rd(SSP_ADDR_DATA, 8'h96, ok);
        results;
    end
endmodule
